// [hdl/ctc_cell2_trim.sv]
// Purpose : Read-only bank of cell-2 ADC temperature trim coefficients.
// Assumes : Host port is single-cycle; trim bytes come from a factory loader.
// Notes   : Host writes never alter the bank; only the trim path loads it.
//
// Chosen here: the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - 0x62: gain2[2:0] in 7:5, gain1[13:9]
// - 0x63: gain2[10:3] across all bits
// - 0x64 bits 2:0 hold gain2[13:11]
// - 0x64 bits 7:3 hold gain3[4:0]
// - 0x65 bits 6:0 hold gain3[11:5]
// - 0x65 bit 7 spare, reads zero
// - 0x66: gain4[7:0] across all bits
// - 0x67 bits 3:0 hold gain4[11:8]
// - 0x67 bits 7:4 hold offset0[3:0]
// - 0x68: offset0[11:4] across all bits
// - All bits read-only, zero after reset
// - gain1 bit0 from 0x60.7, 8:1 from 0x61
// - offset0[13:12] from 0x69 bits 1:0
module ctc_cell2_trim (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    // Host register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [7:0]  reg_rdata_o,
    // Factory trim load path
    input  wire logic        trim_wr_i,
    input  wire logic [7:0]  trim_addr_i,
    input  wire logic [7:0]  trim_data_i,
    output logic             trim_ack_o,
    // Coefficients to the correction datapath
    output logic      [13:0] gain_first_order_coef_o,
    output logic      [13:0] gain_second_order_coef_o,
    output logic      [11:0] gain_third_order_coef_o,
    output logic      [11:0] gain_fourth_order_coef_o,
    output logic      [13:0] offset_zero_order_coef_o,
    output logic             coef_valid_o
);

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    // Index of a trim slice counted from 0x60; valid only when in range.
    function automatic logic [3:0] slice_index(input logic [7:0] addr);
        logic [7:0] diff;
        diff = addr - ctc_pkg::OFS_FIRST_LOW;
        return diff[3:0];
    endfunction : slice_index

    function automatic logic in_trim_range(input logic [7:0] addr);
        return (addr >= ctc_pkg::OFS_FIRST_LOW) && (addr <= ctc_pkg::OFS_O0H);
    endfunction : in_trim_range

    // Only 0x62..0x68 belong to this bank on the host side
    function automatic logic in_host_range(input logic [7:0] addr);
        return (addr >= ctc_pkg::OFS_HOST_FIRST) && (addr <= ctc_pkg::OFS_HOST_LAST);
    endfunction : in_host_range

    // ****************************************************************
    // Signals
    // ****************************************************************
    logic [7:0]  slice      [ctc_pkg::N_SLICE];
    logic [9:0]  slice_load;
    logic [9:0]  loaded;
    logic        locked;
    logic        refused;
    logic        trim_take;
    logic        trim_refuse;
    logic        ctrl_wr;
    logic [7:0]  next_rdata;
    logic [7:0]  status_byte;
    logic [7:0]  ctrl_byte;
    logic [13:0] next_gain1;
    logic [13:0] next_gain2;
    logic [11:0] next_gain3;
    logic [11:0] next_gain4;
    logic [13:0] next_offset0;

    // ****************************************************************
    // Trim load path
    // ****************************************************************
    // Loads are taken only before software locks the bank; once locked
    // the coefficients cannot be disturbed by a stray loader strobe.
    assign trim_take   = trim_wr_i && in_trim_range(trim_addr_i) && !locked;
    assign trim_refuse = trim_wr_i && in_trim_range(trim_addr_i) && locked;
    assign trim_ack_o  = trim_take;

    always_comb begin
        slice_load = '0;
        if (trim_take) begin
            slice_load[slice_index(trim_addr_i)] = 1'b1;
        end
    end

    // ****************************************************************
    // Slice storage
    // ****************************************************************
    // Bits outside each mask are not stored, so spares read zero
    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FIRST_LOW)) u_s60 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[0]),
        .data_i    (trim_data_i),
        .q_o       (slice[0])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s61 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[1]),
        .data_i    (trim_data_i),
        .q_o       (slice[1])
    );

    // Only 0x65 masks a spare bit; the other host slices keep all eight
    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s62 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[2]),
        .data_i    (trim_data_i),
        .q_o       (slice[2])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s63 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[3]),
        .data_i    (trim_data_i),
        .q_o       (slice[3])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s64 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[4]),
        .data_i    (trim_data_i),
        .q_o       (slice[4])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_G3H)) u_s65 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[5]),
        .data_i    (trim_data_i),
        .q_o       (slice[5])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s66 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[6]),
        .data_i    (trim_data_i),
        .q_o       (slice[6])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s67 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[7]),
        .data_i    (trim_data_i),
        .q_o       (slice[7])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_FULL)) u_s68 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[8]),
        .data_i    (trim_data_i),
        .q_o       (slice[8])
    );

    ctc_trim_byte #(.MASK(ctc_pkg::MASK_O0H)) u_s69 (
        .clk_sys_i (clk_sys_i),
        .arst_n_i  (arst_n_i),
        .load_i    (slice_load[9]),
        .data_i    (trim_data_i),
        .q_o       (slice[9])
    );

    // ****************************************************************
    // Load tracking
    // ****************************************************************
    // Loaded bits are only ever set; a reset is the way back
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            loaded <= ctc_pkg::RST_LOADED;
        end else begin
            loaded <= loaded | slice_load;
        end
    end

    // ****************************************************************
    // Control register: lock and refusal flags
    // ****************************************************************
    assign ctrl_wr = reg_wr_i && (reg_addr_i == ctc_pkg::OFS_TRIM_CTRL);

    // Lock is set-only; only a reset reopens the trim path
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            locked <= 1'b0;
        end else if (ctrl_wr && reg_wdata_i[ctc_pkg::CTRL_LOCK_BIT]) begin
            locked <= 1'b1;
        end
    end

    // A refusal in the clearing cycle keeps the flag set
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            refused <= 1'b0;
        end else if (trim_refuse) begin
            refused <= 1'b1;
        end else if (ctrl_wr && reg_wdata_i[ctc_pkg::CTRL_CLR_REF_BIT]) begin
            refused <= 1'b0;
        end
    end

    // ****************************************************************
    // Status and control readback
    // ****************************************************************
    // Unlisted bits of both bytes read zero
    always_comb begin
        status_byte = 8'h00;
        status_byte[ctc_pkg::STAT_LOADED_BIT]  = &loaded;
        status_byte[ctc_pkg::STAT_LOCKED_BIT]  = locked;
        status_byte[ctc_pkg::STAT_REFUSED_BIT] = refused;
        ctrl_byte = 8'h00;
        ctrl_byte[ctc_pkg::CTRL_LOCK_BIT] = locked;
    end

    // ****************************************************************
    // Host read port
    // ****************************************************************
    // Host writes never reach the slices; only the trim path loads them
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            if (in_host_range(reg_addr_i)) begin
                next_rdata = slice[slice_index(reg_addr_i)];
            end else if (reg_addr_i == ctc_pkg::OFS_TRIM_STATUS) begin
                next_rdata = status_byte;
            end else if (reg_addr_i == ctc_pkg::OFS_TRIM_CTRL) begin
                next_rdata = ctrl_byte;
            end
        end
    end

    // Data stand for exactly the cycle after the read strobe
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= ctc_pkg::RST_SLICE;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ****************************************************************
    // Coefficient assembly
    // ****************************************************************
    // Masked-off slice bits are already zero, so the words need no gating
    always_comb begin
        next_gain1   = {slice[2][4:0], slice[1], slice[0][7]};
        next_gain2   = {slice[4][2:0], slice[3], slice[2][7:5]};
        next_gain3   = {slice[5][6:0], slice[4][7:3]};
        next_gain4   = {slice[7][3:0], slice[6]};
        next_offset0 = {slice[9][1:0], slice[8], slice[7][7:4]};
    end

    // Registered so the datapath sees one coherent word per coefficient
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gain_first_order_coef_o  <= ctc_pkg::RST_C14;
            gain_second_order_coef_o <= ctc_pkg::RST_C14;
            gain_third_order_coef_o  <= ctc_pkg::RST_C12;
            gain_fourth_order_coef_o <= ctc_pkg::RST_C12;
            offset_zero_order_coef_o <= ctc_pkg::RST_C14;
        end else begin
            gain_first_order_coef_o  <= next_gain1;
            gain_second_order_coef_o <= next_gain2;
            gain_third_order_coef_o  <= next_gain3;
            gain_fourth_order_coef_o <= next_gain4;
            offset_zero_order_coef_o <= next_offset0;
        end
    end

    // Valid follows the coefficient registers by the same one cycle
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            coef_valid_o <= 1'b0;
        end else begin
            coef_valid_o <= &loaded;
        end
    end

endmodule : ctc_cell2_trim

`default_nettype wire

// [hdl/ctc_pkg.sv]
// Purpose : Constants for the cell-2 ADC trim coefficient bank.
// Assumes : Byte-wide register space; trim slices arrive from a factory loader.
// Notes   : Offsets are byte addresses of the device register space.

package ctc_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;
    localparam int N_SLICE  = 10;
    localparam int C14_W    = 14;
    localparam int C12_W    = 12;

    // ****************************************************************
    // Offsets of the trim slices (0x60..0x69)
    // ****************************************************************
    localparam logic [7:0] OFS_FIRST_LOW   = 8'h60;
    localparam logic [7:0] OFS_FIRST_MID   = 8'h61;
    localparam logic [7:0] OFS_G2L_G1H     = 8'h62;
    localparam logic [7:0] OFS_G2M         = 8'h63;
    localparam logic [7:0] OFS_G3L_G2H     = 8'h64;
    localparam logic [7:0] OFS_G3H         = 8'h65;
    localparam logic [7:0] OFS_G4L         = 8'h66;
    localparam logic [7:0] OFS_O0L_G4H     = 8'h67;
    localparam logic [7:0] OFS_O0M         = 8'h68;
    localparam logic [7:0] OFS_O0H         = 8'h69;

    // Host-visible window of this bank
    localparam logic [7:0] OFS_HOST_FIRST  = 8'h62;
    localparam logic [7:0] OFS_HOST_LAST   = 8'h68;

    // Bank control and status
    localparam logic [7:0] OFS_TRIM_STATUS = 8'hf0;
    localparam logic [7:0] OFS_TRIM_CTRL   = 8'hf1;

    // ****************************************************************
    // Implemented bits of each slice, indexed from 0x60
    // ****************************************************************
    localparam logic [7:0] MASK_FIRST_LOW  = 8'h80;
    localparam logic [7:0] MASK_FULL       = 8'hff;
    localparam logic [7:0] MASK_G3H        = 8'h7f;
    localparam logic [7:0] MASK_O0H        = 8'h03;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int STAT_LOADED_BIT  = 0;
    localparam int STAT_LOCKED_BIT  = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int CTRL_LOCK_BIT    = 0;
    localparam int CTRL_CLR_REF_BIT = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0]  RST_SLICE   = 8'h00;
    localparam logic [13:0] RST_C14     = 14'h0000;
    localparam logic [11:0] RST_C12     = 12'h000;
    localparam logic [9:0]  RST_LOADED  = 10'h000;

endpackage : ctc_pkg

// [hdl/ctc_trim_byte.sv]
// Purpose : One trim byte, loadable only from the factory trim path.
// Assumes : Load strobe is synchronous to clk_sys_i.
// Notes   : Bits outside MASK never store anything and read as zero.

`timescale 1ns/1ps
`default_nettype none

module ctc_trim_byte #(
    parameter logic [7:0] MASK = 8'hff
) (
    input  wire logic       clk_sys_i,
    input  wire logic       arst_n_i,
    input  wire logic       load_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] q_o
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q_o <= ctc_pkg::RST_SLICE;
        end else if (load_i) begin
            q_o <= data_i & MASK;
        end
    end

endmodule : ctc_trim_byte

`default_nettype wire

// [tb/ctc_cell2_trim_chk.sv]
// Purpose : Port assertions for the cell-2 trim coefficient bank.
// Assumes : One clock, asynchronous active-low reset.
// Notes   : The coefficient-map read check waits until a trim load has reached the outputs.
`timescale 1ns/1ps
`default_nettype none
module ctc_cell2_trim_chk (
    input wire logic        clk_sys_i,
    input wire logic        arst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    input wire logic        trim_wr_i,
    input wire logic [7:0]  trim_addr_i,
    input wire logic [7:0]  trim_data_i,
    input wire logic        trim_ack_o,
    input wire logic [13:0] gain_first_order_coef_o,
    input wire logic [13:0] gain_second_order_coef_o,
    input wire logic [11:0] gain_third_order_coef_o,
    input wire logic [11:0] gain_fourth_order_coef_o,
    input wire logic [13:0] offset_zero_order_coef_o,
    input wire logic        coef_valid_o
);
    // ****
    // Helpers
    // ****
    logic [1:0] quiet;
    logic       seen_ack;
    logic [7:0] exp_q;

    function automatic logic [7:0] slice_of(input logic [7:0] a);
        case (a)
            8'h62: return {gain_second_order_coef_o[2:0], gain_first_order_coef_o[13:9]};
            8'h63: return gain_second_order_coef_o[10:3];
            8'h64: return {gain_third_order_coef_o[4:0], gain_second_order_coef_o[13:11]};
            8'h65: return {1'b0, gain_third_order_coef_o[11:5]};
            8'h66: return gain_fourth_order_coef_o[7:0];
            8'h67: return {offset_zero_order_coef_o[3:0], gain_fourth_order_coef_o[11:8]};
            8'h68: return offset_zero_order_coef_o[11:4];
            default: return 8'h00;
        endcase
    endfunction : slice_of

    // Quiet saturates so reads are only judged once outputs have settled
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet    <= 2'd3;
            seen_ack <= 1'b0;
            exp_q    <= 8'h00;
        end else begin
            quiet    <= trim_wr_i ? 2'd0 : (quiet == 2'd3 ? 2'd3 : quiet + 2'd1);
            seen_ack <= seen_ack | trim_ack_o;
            exp_q    <= slice_of(reg_addr_i);
        end
    end

    // ****
    // Assertions
    // ****
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_load(logic [7:0] a);
        trim_ack_o && trim_addr_i == a;
    endsequence

    chk_rd_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    chk_rd_coef_map: assert property (
        reg_rd_i && quiet == 2'd3 && reg_addr_i inside {[8'h60:8'h69]} |=> reg_rdata_o == exp_q)
        else $error("read byte does not match coefficient slice");
    chk_spare_zero: assert property (
        reg_rd_i && reg_addr_i == 8'h65 |=> !reg_rdata_o[7])
        else $error("spare bit reads one");
    chk_reset_zero: assert property (!seen_ack |-> coef_valid_o == 1'b0 &&
        (gain_first_order_coef_o | gain_second_order_coef_o | offset_zero_order_coef_o) == 14'h0
        && (gain_third_order_coef_o | gain_fourth_order_coef_o) == 12'h000)
        else $error("coefficient not zero before any load");
    chk_load_gain4: assert property (s_load(8'h66) |-> ##2
        gain_fourth_order_coef_o[7:0] == $past(trim_data_i, 2))
        else $error("fourth order low byte not exported");
    chk_load_first: assert property (s_load(8'h60) |-> ##2
        {gain_first_order_coef_o[0], 7'h00} == ($past(trim_data_i, 2) & 8'h80))
        else $error("first order bit zero not exported");
    chk_load_off_hi: assert property (s_load(8'h69) |-> ##2
        {6'h00, offset_zero_order_coef_o[13:12]} == ($past(trim_data_i, 2) & 8'h03))
        else $error("offset top bits not exported");
    chk_wr_ignored: assert property (reg_wr_i && !trim_wr_i && quiet == 2'd3 |=>
        $stable(gain_first_order_coef_o) && $stable(gain_second_order_coef_o) &&
        $stable(gain_third_order_coef_o) && $stable(gain_fourth_order_coef_o) &&
        $stable(offset_zero_order_coef_o))
        else $error("host write changed a coefficient");
    chk_valid_rise: assert property ($rose(coef_valid_o) |-> $past(trim_ack_o, 2))
        else $error("valid rose without a load two cycles before");
endmodule : ctc_cell2_trim_chk
bind ctc_cell2_trim ctc_cell2_trim_chk u_chk (.*);
`default_nettype wire

// [tb/tb_ctc_cell2_trim.sv]
// Purpose : Self-checking bench for the cell-2 trim coefficient bank.
// Assumes : Host reads answer one cycle later; trim bytes come from the loader port.
// Notes   : A ten-byte model keeps loaded slices with their implemented bits.
`timescale 1ns/1ps
`default_nettype none
module tb_ctc_cell2_trim;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i = 1'b0;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, trim_wr_i = 1'b0;
    logic [7:0]  reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic [7:0]  trim_addr_i = 8'h00, trim_data_i = 8'h00, reg_rdata_o;
    logic        trim_ack_o, coef_valid_o;
    logic [13:0] gain_first_order_coef_o, gain_second_order_coef_o, offset_zero_order_coef_o;
    logic [11:0] gain_third_order_coef_o, gain_fourth_order_coef_o;
    logic [7:0]  m [10];
    logic [9:0]  loaded;
    logic        locked_m = 1'b0;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;

    ctc_cell2_trim dut (.*);

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ****
    // Tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic trim(input int i, input logic [7:0] d);
        @(posedge clk_sys_i);
        trim_wr_i   <= 1'b1;
        trim_addr_i <= 8'h60 + 8'(i);
        trim_data_i <= d;
        #1 chk(16'(trim_ack_o), 16'(!locked_m));
        if (!locked_m) begin
            m[i] = d & ((i == 0) ? 8'h80 : (i == 5) ? 8'h7f : (i == 9) ? 8'h03 : 8'hff);
            loaded[i] = 1'b1;
        end
        @(posedge clk_sys_i);
        trim_wr_i <= 1'b0;
    endtask : trim

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 chk(16'(reg_rdata_o), 16'(exp));
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr

    task automatic check_all();
        repeat (3) @(posedge clk_sys_i);
        for (int i = 0; i < 10; i++) begin
            rd(8'h60 + 8'(i), (i > 1 && i < 9) ? m[i] : 8'h00);
        end
        chk(16'(gain_first_order_coef_o), 16'({m[2][4:0], m[1], m[0][7]}));
        chk(16'(gain_second_order_coef_o), 16'({m[4][2:0], m[3], m[2][7:5]}));
        chk(16'(gain_third_order_coef_o), 16'({m[5][6:0], m[4][7:3]}));
        chk(16'(gain_fourth_order_coef_o), 16'({m[7][3:0], m[6]}));
        chk(16'(offset_zero_order_coef_o), 16'({m[9][1:0], m[8], m[7][7:4]}));
        chk(16'(coef_valid_o), 16'(&loaded));
    endtask : check_all

    task automatic do_reset();
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        loaded = 10'h000;
        foreach (m[i]) m[i] = 8'h00;
        locked_m = 1'b0;
    endtask : do_reset

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // ****
    // Main sequence
    // ****
    initial begin
        void'($urandom(32'h4b872e2a));
        do_reset();
        check_all();
        $display("test reset values done");
        for (int r = 0; r < 3; r++) begin
            for (int i = 9; i >= 0; i--) begin
                trim(i, 8'($urandom()));
            end
            check_all();
        end
        $display("test trim loads done");
        for (int a = 8'h62; a <= 8'h68; a++) begin
            wr(8'(a), 8'($urandom()));
        end
        check_all();
        $display("test host writes done");
        wr(ctc_pkg::OFS_TRIM_CTRL, 8'h01);
        locked_m = 1'b1;
        rd(ctc_pkg::OFS_TRIM_CTRL, 8'h01);
        trim(3, 8'($urandom()));
        trim(8, 8'($urandom()));
        rd(ctc_pkg::OFS_TRIM_STATUS, 8'h07);
        wr(ctc_pkg::OFS_TRIM_CTRL, 8'h02);
        rd(ctc_pkg::OFS_TRIM_STATUS, 8'h03);
        check_all();
        $display("test trim lock done");
        do_reset();
        check_all();
        trim(6, 8'($urandom()));
        trim(0, 8'($urandom()));
        trim(9, 8'($urandom()));
        check_all();
        $display("test second reset and partial load done");
        conclude();
    end
endmodule : tb_ctc_cell2_trim
`default_nettype wire
